// ===== rtl/tcz_pkg.sv
// Shared constants, register map and carrier types of the timer/counter zero unit
package tcz_pkg;

  // ----------------------------------------------------------------
  // Basic widths and types
  // ----------------------------------------------------------------
  localparam int BYTE_W = 8;
  localparam int IRQ_W = 2;

  typedef logic [BYTE_W-1:0] tcz_byte_t;
  typedef logic [IRQ_W-1:0] tcz_irq_t;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam tcz_byte_t ADDR_RELOAD = 8'hCD;
  localparam tcz_byte_t ADDR_MODE = 8'hDA;
  localparam tcz_byte_t ADDR_COUNT = 8'hDB;
  localparam tcz_byte_t ADDR_IRQ_STATUS = 8'hDC;
  localparam tcz_byte_t ADDR_IRQ_MASK = 8'hDD;

  // ----------------------------------------------------------------
  // Reset values and counter constants
  // ----------------------------------------------------------------
  localparam tcz_byte_t BYTE_ZERO = 8'h00;
  localparam tcz_byte_t MODE_RESET = 8'h00;
  localparam tcz_byte_t COUNT_RESET = 8'h00;
  localparam tcz_byte_t RELOAD_RESET = 8'h00;
  localparam tcz_byte_t COUNT_MAX = 8'hFF;
  localparam tcz_byte_t COUNT_ZERO = 8'h00;
  localparam tcz_byte_t COUNT_STEP = 8'h01;
  localparam tcz_byte_t PRESC_FULL = 8'hFF;
  localparam tcz_irq_t IRQ_NONE = 2'h0;

  // Interrupt status and mask bit positions
  localparam int IRQ_TIMER_BIT = 0;
  localparam int IRQ_PIN_BIT = 1;

  // Fastest prescale code, divide by two
  localparam logic [2:0] RATE_FASTEST = 3'h7;

  // ----------------------------------------------------------------
  // PWM period boundary masks, selected by {auto_reload, toggle}
  // ----------------------------------------------------------------
  localparam logic [1:0] PWM_SEL_256 = 2'h0;
  localparam logic [1:0] PWM_SEL_64 = 2'h1;
  localparam logic [1:0] PWM_SEL_32 = 2'h2;
  localparam logic [1:0] PWM_SEL_16 = 2'h3;
  localparam tcz_byte_t PWM_MASK_256 = 8'hFF;
  localparam tcz_byte_t PWM_MASK_64 = 8'h3F;
  localparam tcz_byte_t PWM_MASK_32 = 8'h1F;
  localparam tcz_byte_t PWM_MASK_16 = 8'h0F;

  // ----------------------------------------------------------------
  // Mode register layout, bit 7 down to bit 0
  // ----------------------------------------------------------------
  typedef struct packed {
    logic count_enable_bit;
    logic [2:0] prescale_rate_field;
    logic clock_source_select;
    logic auto_reload_enable;
    logic toggle_output_enable;
    logic pwm_output_enable;
  } tcz_mode_t;

  // Register port request
  typedef struct packed {
    tcz_byte_t addr;
    tcz_byte_t wdata;
    logic wr;
    logic rd;
  } tcz_bus_req_t;

endpackage

// ===== rtl/tcz_edge_sync.sv
// Three-stage synchroniser with agreement filter and falling-edge pulse
`timescale 1ns/1ps
`default_nettype none

module tcz_edge_sync
  import tcz_pkg::*;
#(
  parameter int STAGES = 3
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Asynchronous pin
  input wire logic pin_in,
  // Synchronous result
  output logic fall
);

  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  if (STAGES < 3)
  begin : g_bad_stages
    $error("tcz_edge_sync needs at least three stages");
  end

  typedef struct packed {
    logic [STAGES-1:0] sh;
    logic level;
    logic fall;
  } tcz_sync_state_t;

  tcz_sync_state_t st_q;
  tcz_sync_state_t st_d;

  // Level only moves once the last two stages agree; the first stage is never looked at
  always_comb
  begin
    st_d = st_q;
    st_d.sh = {st_q.sh[STAGES-2:0], pin_in};
    st_d.fall = 1'b0;
    if (st_q.sh[STAGES-1] == st_q.sh[STAGES-2])
    begin
      st_d.level = st_q.sh[STAGES-1];
      st_d.fall = st_q.level && !st_q.sh[STAGES-1];
    end
  end

  // Reset to idle high so release gives no false edge
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st_q.sh <= '1;
      st_q.level <= 1'b1;
      st_q.fall <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign fall = st_q.fall;

endmodule

`default_nettype wire

// ===== rtl/tcz_timer_counter_zero.sv
// Timer/counter zero: 8-bit up counter with prescaler, event input, reload, buzzer and PWM
`timescale 1ns/1ps
`default_nettype none

module tcz_timer_counter_zero
  import tcz_pkg::*;
#(
  parameter int SYNC_STAGES = 3
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire tcz_bus_req_t bus_req,
  output logic [BYTE_W-1:0] rd_data,
  // External event pin
  input wire logic event_input_pin,
  // Buzzer / PWM pin
  output logic buzzer_output_pin,
  output logic buzzer_pin_sel,
  // Interrupt
  output logic irq
);

  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  if (SYNC_STAGES < 3)
  begin : g_bad_sync
    $error("SYNC_STAGES must be at least three");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    tcz_mode_t mode;
    tcz_byte_t count;
    tcz_byte_t reload;
    tcz_byte_t presc;
    logic toggle;
    tcz_irq_t status;
    tcz_irq_t mask;
    tcz_byte_t rdata;
    logic irq;
    logic pin_out;
    logic pin_sel;
  } tcz_state_t;

  tcz_state_t st_q;
  tcz_state_t st_d;

  logic ext_fall;
  logic wr_mode;
  logic wr_count;
  logic wr_reload;
  logic wr_mask;
  logic rd_status;
  tcz_byte_t div_mask;
  logic tick_int;
  logic tick_ext;
  logic tick;
  logic hw_ovf;
  logic reload_active;
  tcz_byte_t pwm_mask;
  logic pwm_level;
  tcz_irq_t irq_set;

  // ----------------------------------------------------------------
  // Event pin synchroniser
  // ----------------------------------------------------------------
  tcz_edge_sync #(
    .STAGES(SYNC_STAGES)
  ) u_event_sync (
    .clk(clk),
    .rst(rst),
    .pin_in(event_input_pin),
    .fall(ext_fall)
  );

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  // Write and read hits; unmapped addresses are simply ignored
  assign wr_mode = bus_req.wr && (bus_req.addr == ADDR_MODE);
  assign wr_count = bus_req.wr && (bus_req.addr == ADDR_COUNT);
  assign wr_reload = bus_req.wr && (bus_req.addr == ADDR_RELOAD);
  assign wr_mask = bus_req.wr && (bus_req.addr == ADDR_IRQ_MASK);
  assign rd_status = bus_req.rd && (bus_req.addr == ADDR_IRQ_STATUS);

  // ----------------------------------------------------------------
  // Count sources
  // ----------------------------------------------------------------
  // Prescaler tick when the low bits selected by the rate field are all ones
  assign div_mask = PRESC_FULL >> st_q.mode.prescale_rate_field;
  assign tick_int = st_q.mode.count_enable_bit && !st_q.mode.clock_source_select &&
                    ((st_q.presc & div_mask) == div_mask);
  // Pin edges count only while enabled; the rate field plays no part here
  assign tick_ext = st_q.mode.count_enable_bit && st_q.mode.clock_source_select && ext_fall;
  assign tick = tick_int || tick_ext;
  assign hw_ovf = tick && (st_q.count == COUNT_MAX);

  // Reload is meaningless in PWM mode, its bit then picks the boundary
  assign reload_active = st_q.mode.auto_reload_enable && !st_q.mode.pwm_output_enable;

  // ----------------------------------------------------------------
  // PWM boundary and duty
  // ----------------------------------------------------------------
  // Boundary mask from the reload and toggle bits
  always_comb
  begin
    unique case ({st_q.mode.auto_reload_enable, st_q.mode.toggle_output_enable})
      PWM_SEL_256: pwm_mask = PWM_MASK_256;
      PWM_SEL_64: pwm_mask = PWM_MASK_64;
      PWM_SEL_32: pwm_mask = PWM_MASK_32;
      PWM_SEL_16: pwm_mask = PWM_MASK_16;
    endcase
    // Event counting always runs on the full 256 boundary, whatever the two bits say
    if (st_q.mode.clock_source_select)
    begin
      pwm_mask = PWM_MASK_256;
    end
  end

  // High while the count inside the boundary is below the reload value; low when stopped
  assign pwm_level = st_q.mode.count_enable_bit &&
                     ((st_q.count & pwm_mask) < (st_q.reload & pwm_mask));

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    st_d = st_q;
    st_d.rdata = BYTE_ZERO;
    irq_set = IRQ_NONE;

    // Prescaler restarts from zero whenever the timer is stopped, so the first step is a full period
    if (st_q.mode.count_enable_bit)
    begin
      st_d.presc = st_q.presc + COUNT_STEP;
    end
    else
    begin
      st_d.presc = BYTE_ZERO;
    end

    // Counter: step, wrap and optional reload
    if (tick)
    begin
      if (st_q.count == COUNT_MAX)
      begin
        st_d.count = reload_active ? st_q.reload : COUNT_ZERO;
      end
      else
      begin
        st_d.count = st_q.count + COUNT_STEP;
      end
    end

    // Software write takes priority over a step in the same cycle
    if (wr_count)
    begin
      st_d.count = bus_req.wdata;
    end
    if (wr_reload)
    begin
      st_d.reload = bus_req.wdata;
    end
    if (wr_mode)
    begin
      st_d.mode = tcz_mode_t'(bus_req.wdata);
    end
    if (wr_mask)
    begin
      st_d.mask = bus_req.wdata[IRQ_W-1:0];
    end

    // Buzzer toggle flips on every overflow outside PWM mode; with no steps it simply freezes
    if (hw_ovf && !st_q.mode.pwm_output_enable)
    begin
      st_d.toggle = !st_q.toggle;
    end

    // Pin function: PWM level or toggle, pin leaves I/O only when one is enabled
    st_d.pin_out = st_q.mode.pwm_output_enable ? pwm_level : st_d.toggle;
    st_d.pin_sel = st_q.mode.pwm_output_enable || st_q.mode.toggle_output_enable;

    // Request on any change away from all ones, whoever caused it
    irq_set[IRQ_TIMER_BIT] = (st_q.count == COUNT_MAX) && (st_d.count != COUNT_MAX);
    // Pin edges raise the pin flag only while the pin is not the count source
    irq_set[IRQ_PIN_BIT] = ext_fall && !st_q.mode.clock_source_select;

    // Read clears, a set in the same cycle wins
    if (rd_status)
    begin
      st_d.status = IRQ_NONE;
    end
    st_d.status = st_d.status | irq_set;
    // Pin flag pinned to zero in event-counter mode
    if (st_q.mode.clock_source_select)
    begin
      st_d.status[IRQ_PIN_BIT] = 1'b0;
    end

    // Level interrupt from unmasked sticky bits
    st_d.irq = |(st_d.status & st_d.mask);

    // Read data, valid only in the cycle after the strobe
    if (bus_req.rd)
    begin
      unique case (bus_req.addr)
        ADDR_MODE: st_d.rdata = tcz_byte_t'(st_q.mode);
        ADDR_COUNT: st_d.rdata = st_q.count;
        ADDR_IRQ_STATUS: st_d.rdata = tcz_byte_t'(st_q.status);
        ADDR_IRQ_MASK: st_d.rdata = tcz_byte_t'(st_q.mask);
        default: st_d.rdata = BYTE_ZERO; // Reload is write-only and reads as zero
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Everything clears: stopped, internal source, divide by 256
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st_q <= '0;
      st_q.mode <= tcz_mode_t'(MODE_RESET);
      st_q.count <= COUNT_RESET;
      st_q.reload <= RELOAD_RESET;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // Outputs straight from flops
  assign rd_data = st_q.rdata;
  assign irq = st_q.irq;
  assign buzzer_output_pin = st_q.pin_out;
  assign buzzer_pin_sel = st_q.pin_sel;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  a_count_wrap: assert property (
    hw_ovf && !reload_active && !wr_count |=> st_q.count == COUNT_ZERO && st_q.status[IRQ_TIMER_BIT])
    else $error("counter did not wrap to zero with request");

  a_fastest_rate: assert property (
    (tick_int && st_q.mode.prescale_rate_field == RATE_FASTEST && !wr_mode) ##1 !wr_mode
    |-> !tick_int ##1 tick_int)
    else $error("divide by two rate did not tick every other cycle");

  a_hold_stopped: assert property (
    !st_q.mode.count_enable_bit && !wr_count |=> $stable(st_q.count))
    else $error("counter moved while stopped");

  a_ext_step: assert property (
    st_q.mode.count_enable_bit && st_q.mode.clock_source_select && ext_fall &&
    st_q.count != COUNT_MAX && !wr_count |=> st_q.count == $past(st_q.count) + COUNT_STEP)
    else $error("pin edge did not step counter");

  a_ext_only: assert property (
    st_q.mode.clock_source_select && !ext_fall && !wr_count |=> $stable(st_q.count))
    else $error("counter moved without pin edge in event mode");

  a_pin_flag_zero: assert property (
    st_q.mode.clock_source_select |=> !st_q.status[IRQ_PIN_BIT])
    else $error("pin request flag set in event mode");

  a_reload_copy: assert property (
    hw_ovf && reload_active && !wr_count |=> st_q.count == $past(st_q.reload))
    else $error("reload value not copied on overflow");

  a_pwm_wrap: assert property (
    hw_ovf && st_q.mode.pwm_output_enable && !wr_count |=> st_q.count == COUNT_ZERO)
    else $error("PWM mode overflow not at 256 counts");

  a_buzz_toggle: assert property (
    hw_ovf && !st_q.mode.pwm_output_enable |=> st_q.pin_out != $past(st_q.pin_out))
    else $error("buzzer output did not toggle on overflow");

  a_pin_gpio: assert property (
    !st_q.mode.pwm_output_enable && !st_q.mode.toggle_output_enable |=> !st_q.pin_sel)
    else $error("pin taken from I/O with no output function");

  a_pwm_boundary: assert property (
    st_q.mode.pwm_output_enable && st_q.mode.count_enable_bit && !st_q.mode.clock_source_select &&
    st_q.mode.auto_reload_enable && st_q.mode.toggle_output_enable &&
    st_q.count[3:0] == 4'h0 && st_q.reload[3:0] != 4'h0 |=> st_q.pin_out)
    else $error("PWM not high at start of 16 boundary");

  a_ff_leave: assert property (
    st_q.count == COUNT_MAX ##1 st_q.count != COUNT_MAX |-> st_q.status[IRQ_TIMER_BIT])
    else $error("leaving all ones did not raise request");

  a_stop_halt: assert property (
    !st_q.mode.count_enable_bit && st_q.mode.pwm_output_enable |=> !st_q.pin_out)
    else $error("PWM output active while stopped");

  a_reset_clear: assert property (
    @(posedge clk) disable iff (1'b0)
    rst |=> tcz_byte_t'(st_q.mode) == MODE_RESET && st_q.count == COUNT_RESET && st_q.reload == RELOAD_RESET)
    else $error("registers not cleared by reset");

  c_reload_ovf: cover property (hw_ovf && reload_active);
  c_event_step: cover property (tick_ext);
  c_pwm_run: cover property (st_q.mode.pwm_output_enable && st_q.pin_out);
  c_buzz_irq: cover property (hw_ovf && st_q.mode.toggle_output_enable ##1 irq);

endmodule

`default_nettype wire

// ===== test/tcz_pin_model.sv
// Event pin driver and buzzer pin watcher standing outside the timer unit
`timescale 1ns/1ps
`default_nettype none

module tcz_pin_model
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Bench commands
  input wire logic fire,
  input wire logic slow,
  input wire logic clr,
  // Pins
  input wire logic buzz,
  input wire logic buzz_sel,
  output logic pin,
  output logic [7:0] flips
);
  logic [4:0] ph_q;
  logic buzz_q;

  // ----------------------------------------------------------------
  // Event pulse: low half then high half
  // ----------------------------------------------------------------
  // Slow pulses stretch both halves; each half outlasts the input filter
  always_ff @(posedge clk)
  begin
    if (rst || fire)
      ph_q <= fire ? (slow ? 5'h10 : 5'h08) : 5'h00;
    else if (ph_q != 5'h00)
      ph_q <= ph_q - 5'h01;
  end
  // Idles high on its pull-up between pulses
  assign pin = !(ph_q > (slow ? 5'h08 : 5'h04));

  // ----------------------------------------------------------------
  // Buzzer watcher
  // ----------------------------------------------------------------
  // Counts level changes only while the pin is taken from general I/O
  always_ff @(posedge clk)
  begin
    buzz_q <= buzz;
    if (rst || clr)
      flips <= 8'h00;
    else if (buzz_sel && (buzz !== buzz_q))
      flips <= flips + 8'h01;
  end
endmodule

`default_nettype wire

// ===== test/tb.sv
// Self-checking bench for the timer/counter zero unit
`timescale 1ns/1ps
`default_nettype none

module tb
  import tcz_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  tcz_bus_req_t req = '0;
  logic [BYTE_W-1:0] rd_data;
  logic ev_pin;
  logic buz;
  logic buz_sel;
  logic irq;
  logic fire = 1'b0;
  logic slow = 1'b0;
  logic clr = 1'b0;
  logic meas = 1'b0;
  logic [7:0] flips;
  tcz_byte_t v;
  int n_fail = 0;
  int n_checks = 0;
  int cyc = 0;
  int hi = 0;

  // ----------------------------------------------------------------
  // Clock, design and pin partner
  // ----------------------------------------------------------------
  always #2.5 clk = ~clk;

  tcz_timer_counter_zero #(.SYNC_STAGES(3)) u_dut (.clk(clk), .rst(rst), .bus_req(req),
    .rd_data(rd_data), .event_input_pin(ev_pin), .buzzer_output_pin(buz),
    .buzzer_pin_sel(buz_sel), .irq(irq));

  tcz_pin_model u_pin (.clk(clk), .rst(rst), .fire(fire), .slow(slow), .clr(clr),
    .buzz(buz), .buzz_sel(buz_sel), .pin(ev_pin), .flips(flips));

  // Hang guard and PWM high-time meter
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (clr)
      hi <= 0;
    else if (meas && buz === 1'b1)
      hi <= hi + 1;
    if (cyc == 12000)
    begin
      n_fail++;
      $display("BAD %0t run too long", $time);
      complete_run();
    end
  end

  // ----------------------------------------------------------------
  // Bus and check helpers
  // ----------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic wr(input tcz_byte_t a, input tcz_byte_t d);
    @(posedge clk);
    req.addr <= a;
    req.wdata <= d;
    req.wr <= 1'b1;
    @(posedge clk);
    req.wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd(input tcz_byte_t a, output tcz_byte_t d);
    @(posedge clk);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge clk);
    req.rd <= 1'b0;
    #1;
    d = rd_data;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic rchk(input tcz_byte_t a, input tcz_byte_t exp, input string what);
    tcz_byte_t d;
    rd(a, d);
    chk(d, exp, what);
  endtask

  task automatic pulse(input logic s);
    @(posedge clk);
    slow <= s;
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
    tick(40);
  endtask

  task automatic complete_run();
    $display("TB: checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rchk(ADDR_MODE, MODE_RESET, "mode reset");
    rchk(ADDR_COUNT, COUNT_RESET, "count reset");
    rchk(ADDR_IRQ_STATUS, BYTE_ZERO, "status reset");
    wr(ADDR_RELOAD, 8'h33);
    rchk(ADDR_RELOAD, BYTE_ZERO, "reload is write only");
    rchk(8'h10, BYTE_ZERO, "unmapped read");
    wr(ADDR_MODE, 8'h5A);
    rchk(ADDR_MODE, 8'h5A, "mode read back");
    chk({7'h00, buz_sel}, 8'h01, "toggle takes the pin");
    wr(ADDR_MODE, MODE_RESET);
    tick(2);
    chk({7'h00, buz_sel}, 8'h00, "pin back to I/O");
    $display("TB: test reset done");
  endtask

  // Eight steps at every prescale code; half a step of slack absorbs the start offset
  task automatic t_rates();
    int div;
    for (int r = 0; r < 8; r++)
    begin
      div = 256 >> r;
      wr(ADDR_COUNT, COUNT_ZERO);
      wr(ADDR_MODE, {1'b1, 3'(r), 4'h0});
      tick(8 * div + div / 2 - 2);
      wr(ADDR_MODE, MODE_RESET);
      rchk(ADDR_COUNT, 8'h08, "steps at rate");
      tick(20);
      rchk(ADDR_COUNT, 8'h08, "held while stopped");
    end
    $display("TB: test rates done");
  endtask

  task automatic t_overflow();
    wr(ADDR_IRQ_MASK, BYTE_ZERO);
    rd(ADDR_IRQ_STATUS, v);
    wr(ADDR_COUNT, 8'hFE);
    wr(ADDR_MODE, 8'hF0);
    tick(8);
    wr(ADDR_MODE, MODE_RESET);
    rd(ADDR_COUNT, v);
    chk({7'h00, (v < 8'h08)}, 8'h01, "wrapped and kept counting");
    chk({7'h00, irq}, 8'h00, "masked request stays quiet");
    wr(ADDR_IRQ_MASK, 8'h01);
    tick(2);
    chk({7'h00, irq}, 8'h01, "unmasked request raises irq");
    rchk(ADDR_IRQ_STATUS, 8'h01, "overflow flag");
    tick(2);
    chk({7'h00, irq}, 8'h00, "read clears request");
    rchk(ADDR_IRQ_STATUS, BYTE_ZERO, "flag cleared");
    $display("TB: test overflow done");
  endtask

  task automatic t_reload_buzz();
    wr(ADDR_RELOAD, 8'hF0); // sixteen steps per period
    wr(ADDR_COUNT, 8'hF0);
    @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    wr(ADDR_MODE, 8'hF6); // toggle with PWM off
    tick(108);
    wr(ADDR_MODE, 8'h76);
    chk(flips, 8'h03, "one flip per overflow");
    tick(20);
    chk(flips, 8'h03, "toggle frozen when stopped");
    chk({7'h00, buz_sel}, 8'h01, "pin kept by toggle");
    rd(ADDR_COUNT, v);
    chk({7'h00, (v >= 8'hF0 && v < 8'hFB)}, 8'h01, "restart from reload");
    $display("TB: test reload done");
  endtask

  task automatic t_swwrite();
    wr(ADDR_MODE, MODE_RESET);
    wr(ADDR_COUNT, COUNT_MAX);
    rd(ADDR_IRQ_STATUS, v);
    wr(ADDR_COUNT, COUNT_ZERO);
    rchk(ADDR_IRQ_STATUS, 8'h01, "flag on write leaving FF");
    $display("TB: test write flag done");
  endtask

  task automatic t_ext();
    wr(ADDR_COUNT, COUNT_ZERO);
    rd(ADDR_IRQ_STATUS, v);
    wr(ADDR_MODE, 8'hF8);
    tick(20);
    rchk(ADDR_COUNT, COUNT_ZERO, "rate ignored");
    for (int i = 0; i < 3; i++)
      pulse(i[0]);
    rchk(ADDR_COUNT, 8'h03, "one step per falling edge");
    rchk(ADDR_IRQ_STATUS, BYTE_ZERO, "pin flag held low");
    wr(ADDR_MODE, 8'h08);
    pulse(1'b0);
    rchk(ADDR_COUNT, 8'h03, "edges ignored when stopped");
    wr(ADDR_MODE, MODE_RESET);
    pulse(1'b0);
    rchk(ADDR_IRQ_STATUS, 8'h02, "pin flag with internal source");
    $display("TB: test event done");
  endtask

  // Duty over 256 steps with reload 08: 4096/N high cycles, plus two early steps
  task automatic t_pwm();
    int e;
    for (int s = 0; s < 4; s++)
    begin
      e = (s == 0) ? 20 : 4096 / (128 >> s) + 4;
      wr(ADDR_MODE, MODE_RESET);
      wr(ADDR_RELOAD, 8'h08);
      wr(ADDR_COUNT, COUNT_ZERO);
      rd(ADDR_IRQ_STATUS, v);
      wr(ADDR_MODE, {4'hF, 1'b0, 2'(s), 1'b1});
      // Meter cleared on the first edge, before the pin carries the PWM level
      clr <= 1'b1;
      meas <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
      tick(200);
      rchk(ADDR_IRQ_STATUS, BYTE_ZERO, "no early overflow");
      tick(314);
      meas <= 1'b0;
      rchk(ADDR_IRQ_STATUS, 8'h01, "overflow after 256 counts");
      chk({7'h00, (hi >= e - 6 && hi <= e + 6)}, 8'h01, "pwm high time");
      wr(ADDR_MODE, {4'h7, 1'b0, 2'(s), 1'b1});
      tick(3);
      chk({7'h00, buz}, 8'h00, "pwm halted when stopped");
    end
    $display("TB: test pwm done");
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    tick(12);
    rst <= 1'b0;
    t_reset();
    t_rates();
    t_overflow();
    t_reload_buzz();
    t_swwrite();
    t_ext();
    t_pwm();
    complete_run();
  end
endmodule

`default_nettype wire
